// ===== shared/cts_pkg.sv
// Purpose: constants and carrier types for the clock trim and sample sync block
// Assumes: 16-bit registers reached through an 8-bit address configuration port
// Notes:   all offsets, field positions and reset values live here
package cts_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0]  OFS_SAMPLE_PERIOD  = 8'h12; // sample_period_setting
   localparam logic [7:0]  OFS_EXT_STARTUP    = 8'h38; // external_trigger_startup_word
   localparam logic [7:0]  OFS_SLOW_TRIM      = 8'h4B; // slow clock control word
   localparam logic [7:0]  OFS_FAST_TRIM      = 8'h4D; // fast_clock_trim
   localparam logic [7:0]  OFS_PIN_SYNC       = 8'h4F; // pin_and_sync_control

   // ------------------------------------------------------------------
   // reset values (reserved bits hold their write-back values)
   // ------------------------------------------------------------------
   localparam logic [15:0] RST_SAMPLE_PERIOD  = 16'h0028;
   localparam logic [15:0] RST_EXT_STARTUP    = 16'h0000;
   localparam logic [15:0] RST_SLOW_TRIM      = 16'h2612;
   localparam logic [15:0] RST_FAST_TRIM      = 16'h0098;
   localparam logic [15:0] RST_PIN_SYNC       = 16'h2090;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int          SLOW_TRIM_LSB      = 0;  // slow trim code [5:0]
   localparam int          SLOW_TRIM_W        = 6;
   localparam int          FAST_TRIM_LSB      = 0;  // fast trim code [7:0]
   localparam int          FAST_TRIM_W        = 8;
   localparam int          BIT_PIN1_OE        = 6;
   localparam int          BIT_PIN1_IE        = 5;
   localparam int          SEL_LSB            = 2;  // sample_trigger_select [3:2]
   localparam int          BIT_PIN0_IE        = 1;

   // sample cycles last four slow ticks per period unit
   localparam int          TICKS_PER_UNIT     = 4;

   // trigger source codes
   localparam logic [1:0]  SEL_INTERNAL       = 2'h0;
   localparam logic [1:0]  SEL_PIN_ZERO       = 2'h1;
   localparam logic [1:0]  SEL_PIN_ONE        = 2'h2;

   // trim codes that go to the two oscillators
   typedef struct packed {
      logic [5:0] slow; // larger code, lower slow frequency
      logic [7:0] fast; // larger code, higher fast frequency
   } cts_trim_t;
endpackage

// ===== rtl/cts_clock_trim_sync.sv
// Purpose: trim codes for both oscillators and sample-start selection
// Assumes: clk 10 MHz; slow_tick is a one-cycle pulse per slow clock period
// Notes:   pin one output level is held low; its function select lives elsewhere
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - slow clock trimmed by 6-bit code
// - zero fastest, all ones slowest slow clock
// - fast clock trimmed by 8-bit code
// - fast code rises with frequency, resets 0x98
// - bit six enables pin one driver
// - bit five enables pin one input
// - selector zero uses internal divided clock
// - selector one triggers on pin zero
// - selector two triggers on pin one
// - internal rate is slow clock over 4xperiod
module cts_clock_trim_sync #(
   parameter int ADDR_W = 8,  // configuration port address width
   parameter int DATA_W = 16  // configuration port data width
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] cfg_addr,
   input  wire logic [DATA_W-1:0] cfg_wdata,
   input  wire logic              cfg_wr,
   input  wire logic              cfg_rd,
   output logic      [DATA_W-1:0] cfg_rdata,
   input  wire logic              slow_tick,
   input  wire logic              general_pin_zero_in,
   input  wire logic              general_pin_one_in,
   output logic                   general_pin_one_out,
   output logic                   general_pin_one_oe,
   output logic                   pin_one_input_enable,
   output logic                   pin_zero_input_enable,
   output cts_pkg::cts_trim_t     trim,
   output logic                   sample_start
);
   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (ADDR_W != 8) begin : g_bad_addr
      $error("cts_clock_trim_sync: ADDR_W must be 8");
   end
   if (DATA_W != 16) begin : g_bad_data
      $error("cts_clock_trim_sync: DATA_W must be 16");
   end

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   logic [15:0] period_reg;   // sample_period_setting
   logic [15:0] startup_reg;  // external_trigger_startup_word, stored only
   logic [15:0] slow_reg;     // slow clock control word
   logic [15:0] fast_reg;     // fast_clock_trim
   logic [15:0] pin_sync_reg; // pin_and_sync_control
   logic [15:0] rdata_reg;    // read answer
   logic [1:0]  sel;          // sample_trigger_select

   assign sel = pin_sync_reg[cts_pkg::SEL_LSB +: 2];

   // configuration writes, whole word, unknown offsets ignored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         period_reg   <= cts_pkg::RST_SAMPLE_PERIOD;
         startup_reg  <= cts_pkg::RST_EXT_STARTUP;
         slow_reg     <= cts_pkg::RST_SLOW_TRIM;
         fast_reg     <= cts_pkg::RST_FAST_TRIM;
         pin_sync_reg <= cts_pkg::RST_PIN_SYNC;
      end else if (cfg_wr) begin
         if (cfg_addr == cts_pkg::OFS_SAMPLE_PERIOD) begin
            period_reg <= cfg_wdata;
         end else if (cfg_addr == cts_pkg::OFS_EXT_STARTUP) begin
            startup_reg <= cfg_wdata; // software keeps it in step with the selector
         end else if (cfg_addr == cts_pkg::OFS_SLOW_TRIM) begin
            slow_reg <= cfg_wdata;
         end else if (cfg_addr == cts_pkg::OFS_FAST_TRIM) begin
            fast_reg <= cfg_wdata;
         end else if (cfg_addr == cts_pkg::OFS_PIN_SYNC) begin
            pin_sync_reg <= cfg_wdata;
         end
      end
   end

   // registered reads; unmapped offsets answer zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg <= 16'h0000;
      end else if (cfg_rd) begin
         if (cfg_addr == cts_pkg::OFS_SAMPLE_PERIOD) begin
            rdata_reg <= period_reg;
         end else if (cfg_addr == cts_pkg::OFS_EXT_STARTUP) begin
            rdata_reg <= startup_reg;
         end else if (cfg_addr == cts_pkg::OFS_SLOW_TRIM) begin
            rdata_reg <= slow_reg;
         end else if (cfg_addr == cts_pkg::OFS_FAST_TRIM) begin
            rdata_reg <= fast_reg;
         end else if (cfg_addr == cts_pkg::OFS_PIN_SYNC) begin
            rdata_reg <= pin_sync_reg;
         end else begin
            rdata_reg <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------------
   // oscillator trim and pin enables, straight from register bits
   // ------------------------------------------------------------------
   // codes pass unmodified: the analog trim cells own the direction,
   // slow falls as its code rises, fast rises as its code rises
   // one assignment for the whole struct, so the port variable has a single driver
   assign trim = {slow_reg[cts_pkg::SLOW_TRIM_LSB +: cts_pkg::SLOW_TRIM_W],
                  fast_reg[cts_pkg::FAST_TRIM_LSB +: cts_pkg::FAST_TRIM_W]};
   assign general_pin_one_oe    = pin_sync_reg[cts_pkg::BIT_PIN1_OE];
   assign pin_one_input_enable  = pin_sync_reg[cts_pkg::BIT_PIN1_IE];
   assign pin_zero_input_enable = pin_sync_reg[cts_pkg::BIT_PIN0_IE];
   assign cfg_rdata             = rdata_reg;

   // pin one drives low when enabled; other sources are out of scope
   logic pin_one_out_reg;
   always_ff @(posedge clk) begin
      pin_one_out_reg <= 1'b0;
   end
   assign general_pin_one_out = pin_one_out_reg;

   // ------------------------------------------------------------------
   // external trigger edge detect
   // ------------------------------------------------------------------
   logic pin0_gated;  // pin zero seen only with its input enabled
   logic pin1_gated;  // pin one seen only with its input enabled
   logic pin0_prev_reg;
   logic pin1_prev_reg;
   logic pin0_rise;
   logic pin1_rise;

   assign pin0_gated = general_pin_zero_in & pin_sync_reg[cts_pkg::BIT_PIN0_IE];
   assign pin1_gated = general_pin_one_in & pin_sync_reg[cts_pkg::BIT_PIN1_IE];
   assign pin0_rise  = pin0_gated & ~pin0_prev_reg;
   assign pin1_rise  = pin1_gated & ~pin1_prev_reg;

   // previous gated levels for edge detection
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin0_prev_reg <= 1'b0;
         pin1_prev_reg <= 1'b0;
      end else begin
         pin0_prev_reg <= pin0_gated;
         pin1_prev_reg <= pin1_gated;
      end
   end

   // ------------------------------------------------------------------
   // internal sample timer: 4 x period slow ticks per sample
   // ------------------------------------------------------------------
   logic [17:0] tick_cnt_reg;  // slow ticks since last sample
   logic [17:0] tick_limit;    // ticks per sample cycle
   logic        timer_hit;

   assign tick_limit = {period_reg, 2'b00}; // x4
   // a zero period would never expire; the count runs on and wraps without a start
   assign timer_hit  = slow_tick && (tick_limit != 18'h00000)
                       && (tick_cnt_reg == tick_limit - 18'h00001);

   // counter runs only in internal mode so external modes restart cleanly;
   // a period write also restarts it, else a shorter period written mid-count
   // would leave the count past its limit for a whole wrap of the counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_cnt_reg <= 18'h00000;
      end else if (sel != cts_pkg::SEL_INTERNAL) begin
         tick_cnt_reg <= 18'h00000;
      end else if (cfg_wr && cfg_addr == cts_pkg::OFS_SAMPLE_PERIOD) begin
         tick_cnt_reg <= 18'h00000;                  // fresh count per period
      end else if (timer_hit) begin
         tick_cnt_reg <= 18'h00000;
      end else if (slow_tick) begin
         tick_cnt_reg <= tick_cnt_reg + 18'h00001;
      end
   end

   // ------------------------------------------------------------------
   // sample start selection
   // ------------------------------------------------------------------
   logic sample_start_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sample_start_reg <= 1'b0;
      end else begin
         case (sel)
            cts_pkg::SEL_INTERNAL: sample_start_reg <= timer_hit;
            cts_pkg::SEL_PIN_ZERO: sample_start_reg <= pin0_rise;
            cts_pkg::SEL_PIN_ONE:  sample_start_reg <= pin1_rise;
            default:               sample_start_reg <= 1'b0;       // code three idles
         endcase
      end
   end
   assign sample_start = sample_start_reg;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   chk_slow_trim_rst: assert property (@(posedge clk) $past(sys_rst) |-> trim.slow == 6'h12)
      else $error("slow trim not at reset value");
   chk_slow_trim_wr: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_wr && cfg_addr == cts_pkg::OFS_SLOW_TRIM |=> trim.slow == $past(cfg_wdata[5:0]))
      else $error("slow trim code not taken");
   chk_fast_trim_wr: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_wr && cfg_addr == cts_pkg::OFS_FAST_TRIM |=> trim.fast == $past(cfg_wdata[7:0]))
      else $error("fast trim code not taken");
   chk_fast_trim_rst: assert property (@(posedge clk) $past(sys_rst) |-> trim.fast == 8'h98)
      else $error("fast trim not at reset value");
   chk_pin_oe_rst: assert property (@(posedge clk) $past(sys_rst) |-> !general_pin_one_oe)
      else $error("pin one driver enabled after reset");
   chk_pin_ie_rst: assert property (@(posedge clk) $past(sys_rst) |-> !pin_one_input_enable)
      else $error("pin one input enabled after reset");
   chk_internal_start: assert property (@(posedge clk) disable iff (sys_rst)
      sel == cts_pkg::SEL_INTERNAL && slow_tick && period_reg != 16'h0000
      && tick_cnt_reg == tick_limit - 18'h00001 |=> sample_start)
      else $error("internal timer expiry gave no sample start");
   chk_pin0_start: assert property (@(posedge clk) disable iff (sys_rst)
      sel == cts_pkg::SEL_PIN_ZERO && pin0_rise |=> sample_start)
      else $error("pin zero edge gave no sample start");
   chk_pin1_start: assert property (@(posedge clk) disable iff (sys_rst)
      sel == cts_pkg::SEL_PIN_ONE && pin1_rise |=> sample_start)
      else $error("pin one edge gave no sample start");
   chk_period_count: assert property (@(posedge clk) disable iff (sys_rst)
      sample_start && $past(sel) == cts_pkg::SEL_INTERNAL
      |-> $past(tick_cnt_reg) == {$past(period_reg), 2'b00} - 18'h00001)
      else $error("internal sample start at wrong tick count");
   chk_reserved_idle: assert property (@(posedge clk) disable iff (sys_rst)
      sel == 2'h3 |=> !sample_start)
      else $error("reserved selector code gave a sample start");

   cov_internal: cover property (@(posedge clk) sel == cts_pkg::SEL_INTERNAL ##1 sample_start);
   cov_pin0:     cover property (@(posedge clk) sel == cts_pkg::SEL_PIN_ZERO ##1 sample_start);
   cov_pin1:     cover property (@(posedge clk) sel == cts_pkg::SEL_PIN_ONE ##1 sample_start);
endmodule

`default_nettype wire

// ===== bench/cts_clock_trim_sync_test.sv
// Purpose: self-checking bench for the clock trim and sample sync block
// Assumes: registers reached through the cfg strobe port, one access per cycle
// Notes:   inputs change on the falling edge; sample starts counted on the rising edge
`timescale 1ns/1ns
`default_nettype none
module cts_clock_trim_sync_test;
   // ------------------------------------------------------------------
   // stimulus and observation signals
   // ------------------------------------------------------------------
   logic               clk;        // 10 MHz bench clock
   logic               sys_rst;    // synchronous reset, active high
   logic [7:0]         cfg_addr;   // register offset
   logic [15:0]        cfg_wdata;  // write word
   logic               cfg_wr;     // write strobe
   logic               cfg_rd;     // read strobe
   logic [15:0]        cfg_rdata;  // read answer
   logic               slow_tick;  // stands in for the slow oscillator
   logic               pin0;       // pin zero level
   logic               pin1;       // pin one level
   logic               p1_out;     // pin one drive level
   logic               p1_oe;      // pin one driver enable
   logic               p1_ie;      // pin one input enable
   logic               p0_ie;      // pin zero input enable
   cts_pkg::cts_trim_t trim;       // trim codes to both oscillators
   logic               sample_start; // one-cycle start pulse
   int                 bad_count;  // mismatches seen
   int                 n_tests;    // comparisons made
   int                 starts;     // start pulses since last clear
   logic [7:0]         fc [3] = '{8'h00, 8'hFF, 8'h98}; // fast codes: min, max, default
   logic [5:0]         sc [3] = '{6'h00, 6'h22, 6'h3F}; // slow codes: max, centre, min

   cts_clock_trim_sync u_cts_clock_trim_sync (
      .clk(clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .slow_tick(slow_tick),
      .general_pin_zero_in(pin0), .general_pin_one_in(pin1),
      .general_pin_one_out(p1_out), .general_pin_one_oe(p1_oe),
      .pin_one_input_enable(p1_ie), .pin_zero_input_enable(p0_ie),
      .trim(trim), .sample_start(sample_start));

   // ------------------------------------------------------------------
   // clock, start counter, watchdog
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // count pulses on the rising edge where they are settled
   always @(posedge clk) begin
      if (sample_start === 1'b1) begin
         starts++;
      end
   end

   // whole run is well under a thousand cycles; five thousand means a hang
   initial begin
      #(100 * 5000);
      bad_count++;
      conclude();
   end

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe; outputs settle by the next falling edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk) begin cfg_addr = a; cfg_wdata = d; cfg_wr = 1'b1; end
      @(negedge clk) cfg_wr = 1'b0;
   endtask

   // answer is registered, so look one full cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk) begin cfg_addr = a; cfg_rd = 1'b1; end
      @(negedge clk) cfg_rd = 1'b0;
      @(negedge clk) check(cfg_rdata, e);
   endtask

   // slow ticks two cycles apart, then let the last start land
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk) slow_tick = 1'b1;
         @(negedge clk) slow_tick = 1'b0;
      end
      repeat (3) @(negedge clk);
   endtask

   // one rising edge on the chosen pin, held a few cycles
   task automatic pin(input int which);
      @(negedge clk) if (which == 0) pin0 = 1'b1; else pin1 = 1'b1;
      repeat (3) @(negedge clk);
      pin0 = 1'b0;
      pin1 = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      {sys_rst, cfg_wr, cfg_rd, slow_tick, pin0, pin1} = 6'h20;
      cfg_addr = 8'h00;
      cfg_wdata = 16'h0000;
      bad_count = 0;
      n_tests = 0;
      starts = 0;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      // reset contents and outputs
      rd(cts_pkg::OFS_SAMPLE_PERIOD, 16'h0028);
      rd(cts_pkg::OFS_EXT_STARTUP, 16'h0000);
      rd(cts_pkg::OFS_SLOW_TRIM, 16'h2612);
      rd(cts_pkg::OFS_FAST_TRIM, 16'h0098);
      rd(cts_pkg::OFS_PIN_SYNC, 16'h2090);
      check({8'h00, trim.fast}, 16'h0098);
      check({10'h000, trim.slow}, 16'h0012);
      check({14'h0000, p1_oe, p1_ie}, 16'h0000);
      // trim codes at both ends of each range, plus the fast default and a mid slow code
      for (int i = 0; i < 3; i++) begin
         wr(cts_pkg::OFS_FAST_TRIM, {8'h00, fc[i]});
         check({8'h00, trim.fast}, {8'h00, fc[i]});
         rd(cts_pkg::OFS_FAST_TRIM, {8'h00, fc[i]});
         wr(cts_pkg::OFS_SLOW_TRIM, {10'h098, sc[i]});
         check({10'h000, trim.slow}, {10'h000, sc[i]});
         rd(cts_pkg::OFS_SLOW_TRIM, {10'h098, sc[i]});
      end
      // unmapped write must not alias onto a real register
      wr(8'h00, 16'hFFFF);
      rd(8'h00, 16'h0000);
      rd(cts_pkg::OFS_FAST_TRIM, 16'h0098);
      wr(cts_pkg::OFS_EXT_STARTUP, 16'h4000);
      rd(cts_pkg::OFS_EXT_STARTUP, 16'h4000);
      wr(cts_pkg::OFS_EXT_STARTUP, 16'h0000);
      // pin one driver and input buffer
      wr(cts_pkg::OFS_PIN_SYNC, 16'h20D0);
      check({14'h0000, p1_oe, p1_out}, 16'h0002);
      wr(cts_pkg::OFS_PIN_SYNC, 16'h20B0);
      check({14'h0000, p1_oe, p1_ie}, 16'h0001);
      // internal timing: one start per four ticks of each period unit
      wr(cts_pkg::OFS_PIN_SYNC, 16'h2090);
      wr(cts_pkg::OFS_SAMPLE_PERIOD, 16'h0001);
      starts = 0;
      ticks(8);
      check(16'(starts), 16'h0002);
      wr(cts_pkg::OFS_SAMPLE_PERIOD, 16'h0002);
      starts = 0;
      ticks(8);
      check(16'(starts), 16'h0001);
      wr(cts_pkg::OFS_SAMPLE_PERIOD, 16'h0000);
      starts = 0;
      ticks(8);
      check(16'(starts), 16'h0000);
      // pin zero trigger, ticks ignored, then gated off by its input enable
      wr(cts_pkg::OFS_SAMPLE_PERIOD, 16'h0001);
      wr(cts_pkg::OFS_EXT_STARTUP, 16'h4000);
      wr(cts_pkg::OFS_PIN_SYNC, 16'h2092);
      wr(cts_pkg::OFS_PIN_SYNC, 16'h2096);
      starts = 0;
      pin(0);
      ticks(4);
      pin(1);
      check(16'(starts), 16'h0001);
      wr(cts_pkg::OFS_PIN_SYNC, 16'h2094);
      pin(0);
      check(16'(starts), 16'h0001);
      // pin one trigger; pin zero edges ignored
      wr(cts_pkg::OFS_PIN_SYNC, 16'h20B4);
      wr(cts_pkg::OFS_PIN_SYNC, 16'h20B8);
      starts = 0;
      pin(1);
      pin(0);
      check(16'(starts), 16'h0001);
      // selector three never starts
      wr(cts_pkg::OFS_EXT_STARTUP, 16'h0000);
      wr(cts_pkg::OFS_PIN_SYNC, 16'h20BE);
      starts = 0;
      pin(0);
      pin(1);
      ticks(8);
      check(16'(starts), 16'h0000);
      // back to internal timing, counting restarts from zero
      wr(cts_pkg::OFS_PIN_SYNC, 16'h2090);
      ticks(4);
      check(16'(starts), 16'h0001);
      conclude();
   end
endmodule
`default_nettype wire
